// ---- lbrg_arbiter.sv ----
`timescale 1ns/1ps
module lbrg_arbiter #(
   parameter int MEM_START_CLKS = lbrg_pkg::MEM_START_CLKS,
   parameter int IDLE_GAP_CLKS = lbrg_pkg::IDLE_GAP_CLKS
) (
   input wire logic sys_clk,
   input wire logic rst,
   input lbrg_pkg::lbrg_bus_stat_t busStat,
   input wire logic busHandoverLineHighPrioIn,
   output logic busHandoverLineHighPrioOut,
   output logic busHandoverLineHighPrioOe,
   input wire logic busHandoverLineLowPrioIn,
   output logic busHandoverLineLowPrioOut,
   output logic busHandoverLineLowPrioOe,
   output lbrg_pkg::lbrg_ctl_t ctl_q
);

   localparam logic [1:0] WAIT_MAX = 2'(MEM_START_CLKS);
   localparam logic [1:0] GAP_MAX = 2'(IDLE_GAP_CLKS);

   lbrg_pkg::lbrg_state_t state_q;
   lbrg_pkg::lbrg_state_t state_d;
   logic owner_q;
   logic owner_d;
   logic pendHi_q;
   logic pendHi_d;
   logic pendLo_q;
   logic pendLo_d;
   logic early_q;
   logic early_d;
   logic [1:0] waitCnt_q;
   logic [1:0] waitCnt_d;
   logic [1:0] gapCnt_q;
   logic [1:0] gapCnt_d;
   lbrg_pkg::lbrg_ctl_t ctl_d;

   logic pulseHi;
   logic pulseLo;
   logic driveHiD;
   logic driveLoD;
   logic relOk;
   logic atT4;
   logic activeHi;
   logic activeLo;
   logic reqHi;
   logic reqLo;
   logic ownerPulse;
   logic idleRelease;

   lbrg_pkg::lbrg_pin_drv_t pinHi;
   lbrg_pkg::lbrg_pin_drv_t pinLo;

   lbrg_chan u_chan_hi (
      .sys_clk(sys_clk),
      .rst(rst),
      .lineIn(busHandoverLineHighPrioIn),
      .driveD(driveHiD),
      .pulseSeen(pulseHi),
      .pin_q(pinHi)
   );

   lbrg_chan u_chan_lo (
      .sys_clk(sys_clk),
      .rst(rst),
      .lineIn(busHandoverLineLowPrioIn),
      .driveD(driveLoD),
      .pulseSeen(pulseLo),
      .pin_q(pinLo)
   );

   lbrg_rel_cond u_rel_cond (
      .stat(busStat),
      .reqEarly(early_q),
      .relOk(relOk),
      .atT4(atT4)
   );

   always_comb begin
      busHandoverLineHighPrioOut = pinHi.lineOut;
      busHandoverLineHighPrioOe = pinHi.lineOe;
      busHandoverLineLowPrioOut = pinLo.lineOut;
      busHandoverLineLowPrioOe = pinLo.lineOe;
   end

   // A channel is busy from the clock its request is taken through the trailing gap clock
   always_comb begin
      activeHi = (owner_q == lbrg_pkg::OWN_HI) && (state_q != lbrg_pkg::ST_IDLE);
      activeLo = (owner_q == lbrg_pkg::OWN_LO) && (state_q != lbrg_pkg::ST_IDLE);
      reqHi = pendHi_q || (pulseHi && !activeHi);
      reqLo = pendLo_q || (pulseLo && !activeLo);
      ownerPulse = (owner_q == lbrg_pkg::OWN_HI) ? pulseHi : pulseLo;
      // Bus idle, unlocked and no memory cycle promised: release at once
      idleRelease = !busStat.cycleActive && !busStat.memStartPending && !busStat.locked;
   end

   always_comb begin
      state_d = state_q;
      owner_d = owner_q;
      early_d = early_q;
      waitCnt_d = waitCnt_q;
      gapCnt_d = gapCnt_q;
      // A request on the channel not being served is kept, never dropped
      pendHi_d = pendHi_q || (pulseHi && !activeHi);
      pendLo_d = pendLo_q || (pulseLo && !activeLo);
      case (state_q)
         lbrg_pkg::ST_IDLE: begin
            if (reqHi || reqLo) begin
               owner_d = reqHi ? lbrg_pkg::OWN_HI : lbrg_pkg::OWN_LO;
               if (reqHi) begin
                  pendHi_d = 1'b0;
               end else begin
                  pendLo_d = 1'b0;
               end
               waitCnt_d = 2'h0;
               if (busStat.cycleActive) begin
                  early_d = lbrg_pkg::lbrg_is_early(busStat.tState);
               end else begin
                  early_d = 1'b1;
               end
               if (idleRelease) begin
                  state_d = lbrg_pkg::ST_GRANT;
               end else begin
                  state_d = lbrg_pkg::ST_WAIT;
               end
            end
         end
         lbrg_pkg::ST_WAIT: begin
            if (busStat.cycleActive) begin
               waitCnt_d = 2'h0;
               // A late request is honoured from the next cycle's start
               if (busStat.tState == lbrg_pkg::T_STATE_1) begin
                  early_d = 1'b1;
               end
               if (atT4 && relOk) begin
                  state_d = lbrg_pkg::ST_GRANT;
               end
            end else begin
               early_d = 1'b1;
               if (waitCnt_q != WAIT_MAX) begin
                  waitCnt_d = waitCnt_q + 2'h1;
               end
               // Give up on a promised memory cycle that never starts
               if (!busStat.locked &&
                   (!busStat.memStartPending || waitCnt_q == WAIT_MAX)) begin
                  state_d = lbrg_pkg::ST_GRANT;
               end
            end
         end
         lbrg_pkg::ST_GRANT: begin
            state_d = lbrg_pkg::ST_HOLD;
         end
         lbrg_pkg::ST_HOLD: begin
            if (ownerPulse) begin
               gapCnt_d = 2'h0;
               state_d = lbrg_pkg::ST_GAP;
            end
         end
         lbrg_pkg::ST_GAP: begin
            gapCnt_d = gapCnt_q + 2'h1;
            if (gapCnt_q + 2'h1 >= GAP_MAX) begin
               state_d = lbrg_pkg::ST_IDLE;
            end
         end
         default: begin
            state_d = lbrg_pkg::ST_IDLE;
         end
      endcase
   end

   // Grant pulse is the second of the three; the chan flop drives it one clock
   always_comb begin
      driveHiD = (state_d == lbrg_pkg::ST_GRANT) && (owner_d == lbrg_pkg::OWN_HI);
      driveLoD = (state_d == lbrg_pkg::ST_GRANT) && (owner_d == lbrg_pkg::OWN_LO);
   end

   always_comb begin
      // Float from the grant clock; the engine must see it before any new T1
      ctl_d.floatBus = (state_d == lbrg_pkg::ST_GRANT) ||
                       (state_d == lbrg_pkg::ST_HOLD);
      ctl_d.holdAck = (state_d == lbrg_pkg::ST_HOLD);
      ctl_d.reqWaiting = (state_d == lbrg_pkg::ST_WAIT);
      ctl_d.ownerLow = owner_d;
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         state_q <= lbrg_pkg::ST_IDLE;
         owner_q <= lbrg_pkg::OWN_HI;
         pendHi_q <= 1'b0;
         pendLo_q <= 1'b0;
         early_q <= 1'b0;
         waitCnt_q <= 2'h0;
         gapCnt_q <= 2'h0;
         ctl_q <= '0;
      end else begin
         state_q <= state_d;
         owner_q <= owner_d;
         pendHi_q <= pendHi_d;
         pendLo_q <= pendLo_d;
         early_q <= early_d;
         waitCnt_q <= waitCnt_d;
         gapCnt_q <= gapCnt_d;
         ctl_q <= ctl_d;
      end
   end

endmodule : lbrg_arbiter

// ---- lbrg_pkg.sv ----
// Notes on behaviour
// - A bus handover is three active-low pulses on the shared request/grant line.
// - After each handover, at least one idle clock passes before a new exchange.
// - A request during an active cycle releases the bus at T4 when conditions hold.
// - Release this cycle needs the request seen by T2; later requests wait a cycle.
// - Never release after the low byte of a word; wait for the high byte.
// - Never release after the first acknowledge of an interrupt acknowledge pair.
// - No release while a locked instruction executes.
// - With the bus idle at request time, release may happen on the next clock.
// - With the bus idle, a memory cycle may instead start within three clocks.
// - That memory cycle uses the active-cycle conditions with request timing already met.
// - Grant is one low clock in T4 or T1; bus floats and hold follows.
// - The requester ends with a third one-clock pulse; bus returns next clock.
// - On simultaneous requests the high-priority channel is served first.
package lbrg_pkg;

   localparam logic [1:0] T_STATE_1 = 2'h0;
   localparam logic [1:0] T_STATE_2 = 2'h1;
   localparam logic [1:0] T_STATE_3 = 2'h2;
   localparam logic [1:0] T_STATE_4 = 2'h3;

   localparam int PULSES_PER_HANDOVER = 3;
   localparam int IDLE_GAP_CLKS = 1;
   localparam int MEM_START_CLKS = 3;

   localparam logic OWN_HI = 1'b0;
   localparam logic OWN_LO = 1'b1;

   localparam logic LINE_RELEASED = 1'b1;

   // Gray codes along idle -> wait -> grant -> hold -> gap
   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_WAIT = 3'h1,
      ST_GRANT = 3'h3,
      ST_HOLD = 3'h2,
      ST_GAP = 3'h6
   } lbrg_state_t;

   // Status from the bus cycle engine, same clock
   typedef struct packed {
      logic cycleActive;
      logic [1:0] tState;
      logic lowByte;
      logic firstIntAck;
      logic locked;
      logic memStartPending;
   } lbrg_bus_stat_t;

   // Control back to the bus cycle engine
   typedef struct packed {
      logic floatBus;
      logic holdAck;
      logic reqWaiting;
      logic ownerLow;
   } lbrg_ctl_t;

   typedef struct packed {
      logic lineOut;
      logic lineOe;
   } lbrg_pin_drv_t;

   function automatic logic lbrg_is_early(input logic [1:0] ts);
      return (ts == T_STATE_1) || (ts == T_STATE_2);
   endfunction : lbrg_is_early

endpackage : lbrg_pkg

// ---- lbrg_chan.sv ----
`timescale 1ns/1ps
module lbrg_chan (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic lineIn,
   input wire logic driveD,
   output logic pulseSeen,
   output lbrg_pkg::lbrg_pin_drv_t pin_q
);

   lbrg_pkg::lbrg_pin_drv_t pin_d;

   // Partner runs on our clock, so the pin is used without synchronisers
   always_comb begin
      pulseSeen = ~lineIn & ~pin_q.lineOe;
   end

   always_comb begin
      pin_d.lineOut = ~driveD;
      pin_d.lineOe = driveD;
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         pin_q.lineOut <= lbrg_pkg::LINE_RELEASED;
         pin_q.lineOe <= 1'b0;
      end else begin
         pin_q <= pin_d;
      end
   end

endmodule : lbrg_chan

// ---- lbrg_rel_cond.sv ----
`timescale 1ns/1ps
module lbrg_rel_cond (
   input lbrg_pkg::lbrg_bus_stat_t stat,
   input wire logic reqEarly,
   output logic relOk,
   output logic atT4
);

   always_comb begin
      atT4 = stat.cycleActive && (stat.tState == lbrg_pkg::T_STATE_4);
      relOk = reqEarly
         && !stat.lowByte
         && !stat.firstIntAck
         && !stat.locked;
   end

endmodule : lbrg_rel_cond

// ---- lbrg_arbiter_properties.sv ----
`timescale 1ns/1ps
module lbrg_checker (
   input wire logic sys_clk,
   input wire logic rst,
   input lbrg_pkg::lbrg_bus_stat_t busStat,
   input wire logic busHandoverLineHighPrioIn,
   input wire logic busHandoverLineHighPrioOut,
   input wire logic busHandoverLineHighPrioOe,
   input wire logic busHandoverLineLowPrioIn,
   input wire logic busHandoverLineLowPrioOut,
   input wire logic busHandoverLineLowPrioOe,
   input lbrg_pkg::lbrg_ctl_t ctl_q
);
   wire hiG = busHandoverLineHighPrioOe;
   wire loG = busHandoverLineLowPrioOe;
   // Own grant also pulls the line, so a request is a low line we do not drive
   wire hiR = !busHandoverLineHighPrioIn && !hiG;
   wire quiet = !ctl_q.floatBus && !ctl_q.reqWaiting;
   wire act = busStat.cycleActive;
   wire t4 = act && busStat.tState == lbrg_pkg::T_STATE_4;
   wire t4ok = t4 && !busStat.lowByte && !busStat.firstIntAck && !busStat.locked;
   default clocking dc @(posedge sys_clk); endclocking
   default disable iff (rst);
   sequence reqT2; quiet && hiR && act && busStat.tState == lbrg_pkg::T_STATE_2; endsequence
   sequence reqT3; quiet && hiR && act && busStat.tState == lbrg_pkg::T_STATE_3; endsequence
   grant_one_clk_a:
      assert property (hiG |=> !hiG) else $error("grant too wide");
   grant_low_a:
      assert property (hiG |-> !busHandoverLineHighPrioOut && ctl_q.floatBus) else $error("grant level");
   hold_follows_a:
      assert property (hiG |=> ctl_q.holdAck) else $error("no hold after grant");
   idle_grant_a:
      assert property (quiet && hiR && !act && !busStat.locked && !busStat.memStartPending
         |=> hiG && !loG) else $error("idle grant late");
   t4_grant_a:
      assert property (reqT2 ##2 t4ok |=> hiG) else $error("no grant after T4");
   late_defer_a:
      assert property (reqT3 ##1 t4 |=> !hiG) else $error("late request granted");
   no_release_a:
      assert property (t4 && (busStat.lowByte || busStat.firstIntAck) |=> !hiG && !loG)
         else $error("split cycle released");
   lock_block_a:
      assert property (busStat.locked |=> !hiG && !loG) else $error("locked release");
endmodule : lbrg_checker

bind lbrg_arbiter lbrg_checker lbrg_checker_i (.*);

// ---- lbrg_master_model.sv ----
`timescale 1ns/1ps
module lbrg_master_model (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic lineIn,
   input wire logic go,
   input wire logic [3:0] holdClks,
   output logic drvLow,
   output logic busy
);
   logic [4:0] cnt_q;
   assign busy = cnt_q != 5'h0;
   // Pull-up line: we only ever pull low, one clock at a time
   always @(posedge sys_clk) begin
      if (rst) begin
         drvLow <= 1'h0;
         cnt_q <= 5'h0;
      end else if (go && !busy) begin
         drvLow <= 1'h1;
         cnt_q <= 5'h1;
      end else if (cnt_q == 5'h2) begin
         drvLow <= 1'h1;
         cnt_q <= 5'h0;
      end else begin
         drvLow <= 1'h0;
         if (cnt_q == 5'h1 && !lineIn && !drvLow) cnt_q <= 5'(holdClks) + 5'h2;
         else if (cnt_q > 5'h2) cnt_q <= cnt_q - 5'h1;
      end
   end
endmodule : lbrg_master_model

// ---- test_local_bus_request_grant.sv ----
`timescale 1ns/1ps
module test_local_bus_request_grant;
   logic sys_clk = 1'h0;
   logic rst = 1'h1;
   lbrg_pkg::lbrg_bus_stat_t bs = '0;
   lbrg_pkg::lbrg_ctl_t ctl;
   logic goHi = 1'h0, goLo = 1'h0;
   logic [3:0] hiHold = 4'h0, loHold = 4'h0;
   logic hiOut, hiOe, loOut, loOe, hiDrv, loDrv, hiBusy, loBusy;
   logic gnt = 1'h0, endSeen = 1'h0;
   int seed = 27350, cyc = 0, n_errors = 0, cmp_count = 0, e;
   int expQ[$];
   wire hiLine = !(hiOe && !hiOut) && !hiDrv;
   wire loLine = !(loOe && !loOut) && !loDrv;
   always #12.5 sys_clk = ~sys_clk;
   lbrg_arbiter lbrg_arbiter_i (.sys_clk(sys_clk), .rst(rst), .busStat(bs),
      .busHandoverLineHighPrioIn(hiLine), .busHandoverLineHighPrioOut(hiOut),
      .busHandoverLineHighPrioOe(hiOe), .busHandoverLineLowPrioIn(loLine),
      .busHandoverLineLowPrioOut(loOut), .busHandoverLineLowPrioOe(loOe), .ctl_q(ctl));
   lbrg_master_model hi_i (.sys_clk(sys_clk), .rst(rst), .lineIn(hiLine), .go(goHi),
      .holdClks(hiHold), .drvLow(hiDrv), .busy(hiBusy));
   lbrg_master_model lo_i (.sys_clk(sys_clk), .rst(rst), .lineIn(loLine), .go(goLo),
      .holdClks(loHold), .drvLow(loDrv), .busy(loBusy));
   task check(input logic [31:0] seen, input logic [31:0] want);
      cmp_count++;
      if (seen !== want) begin
         n_errors++;
         $display("unexpected at %0t: got %0h want %0h", $time, seen, want);
      end
   endtask : check
   task tally_and_finish;
      $display("compares %0d errors %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : tally_and_finish
   // Three quiet clocks also give the idle gap before the next exchange
   task settle;
      int q;
      q = 0;
      for (int n = 0; n < 300 && q < 3; n++) begin
         @(posedge sys_clk);
         q = ({hiBusy, loBusy, ctl.floatBus, ctl.reqWaiting} === 4'h0) ? q + 1 : 0;
      end
   endtask : settle
   // Request at edge at; m bus cycles from edge s, first nf flagged with f
   task act(input int at, s, m, nf, input logic [2:0] f, input logic mp, input int ch);
      int k;
      lbrg_pkg::lbrg_bus_stat_t b;
      k = cyc;
      expQ.push_back((ch == 1 ? 1000000 : 0) + (m == 0 ? k + 3 : k + 1 + s + 4 * m));
      if (ch == 2) expQ.push_back(1000000);
      hiHold <= 4'($random(seed));
      loHold <= 4'($random(seed));
      for (int i = 0; i < 16; i++) begin
         b = '0;
         b.memStartPending = mp && i < s;
         if (i >= s && i < s + 4 * m)
            b = {1'h1, 2'(i - s), (i - s < 4 * nf) ? f : 3'h0, 1'h0};
         goHi <= i == at && ch != 1;
         goLo <= i == at && ch != 0;
         bs <= b;
         @(posedge sys_clk);
      end
      settle();
   endtask : act
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      gnt <= hiOe === 1'h1 || loOe === 1'h1;
      // The owner's end pulse seen during hold hands the bus back one clock later
      endSeen <= ctl.holdAck === 1'h1 && (ctl.ownerLow ? loDrv : hiDrv) === 1'h1;
      if (gnt) check(ctl.holdAck, 1);
      if (endSeen) check({ctl.floatBus, ctl.holdAck}, 0);
      if (hiOe === 1'h1 || loOe === 1'h1) begin
         e = expQ.size() ? expQ.pop_front() : -1;
         check(loOe, e / 1000000);
         check(ctl.ownerLow, e / 1000000);
         check(ctl.floatBus, 1);
         if (e % 1000000) check(cyc, e % 1000000);
         check(hiOe ? hiOut : loOut, 0);
      end
   end
   initial begin
      #125000;
      n_errors++;
      tally_and_finish;
   end
   initial begin
      repeat (8) @(posedge sys_clk);
      rst <= 1'h0;
      @(posedge sys_clk);
      act(0, 0, 0, 0, 3'h0, 1'h0, 0);
      act(0, 0, 0, 0, 3'h0, 1'h0, 1);
      act(0, 0, 0, 0, 3'h0, 1'h0, 2);
      act(0, 0, 1, 0, 3'h0, 1'h0, 0);
      act(1, 0, 2, 0, 3'h0, 1'h0, 0);
      act(0, 0, 2, 1, 3'h4, 1'h0, 0);
      act(0, 0, 2, 1, 3'h2, 1'h0, 1);
      act(0, 0, 3, 2, 3'h1, 1'h0, 0);
      act(0, 2, 1, 0, 3'h0, 1'h1, 0);
      check(expQ.size(), 0);
      tally_and_finish;
   end
endmodule : test_local_bus_request_grant
